// File: design/fctc_defines.vh
// Constants for the fan tachometer period counter block
// What this block does
// - Mode bits pick fan or analog; reset fan
// - Count reference clock over two tach periods
// - Start bit one, alert-clear zero starts monitoring
// - Open on rising edge, close two edges later
// - Fans in turn; end at two cycles or 255
// - Results stored per fan, refreshed while running
// - Prescaler 1/2/4/8 per fan, default 2
// - Divisor fields in upper four register bits
// - Count equals ref*60 over rpm times divisor
// - Fault when count above low-speed limit
// - Fault bit follows each new comparison result
`ifndef FCTC_DEFINES_VH
`define FCTC_DEFINES_VH

// Clock and reference oscillator rates in Hz
`define FCTC_CLK_HZ 50000000
`define FCTC_REF_HZ 22500
`define FCTC_REF_DIV_W 12

// APB register byte offsets
`define FCTC_OFS_CONFIG 8'h00
`define FCTC_OFS_CHMODE 8'h04
`define FCTC_OFS_VIDDIV 8'h08
`define FCTC_OFS_VAL1 8'h0c
`define FCTC_OFS_VAL2 8'h10
`define FCTC_OFS_LIM1 8'h14
`define FCTC_OFS_LIM2 8'h18
`define FCTC_OFS_STAT 8'h1c
`define FCTC_OFS_MASK 8'h20
`define FCTC_OFS_FAULT 8'h24

// Configuration register bits
`define FCTC_CFG_START 0
`define FCTC_CFG_ALERT_EN 1
`define FCTC_CFG_ALERT_CLR 3

// Divisor field positions in the voltage-id/prescale register
`define FCTC_DIV1_LSB 4
`define FCTC_DIV2_LSB 6
`define FCTC_VIDDIV_RST 4'h5
`define FCTC_LIM_RST 8'hff

// Measurement states
`define FCTC_S_IDLE 2'h0
`define FCTC_S_ARM 2'h1
`define FCTC_S_CNT 2'h2
`define FCTC_S_DONE 2'h3

`endif

// File: design/fctc_divider.v
// Enable divider producing one pulse every ratio_in enabled cycles
`default_nettype none
module fctc_divider #(
    parameter W = 12
) (
    input wire clk_in,
    input wire rst_in,
    input wire clr_in,
    input wire en_in,
    input wire [W-1:0] ratio_in,
    output wire pulse_out
);
    reg [W-1:0] cnt; // Enabled cycles seen so far
    wire last; // Final count of this period

    assign last = (cnt == ratio_in - {{(W-1){1'b0}}, 1'b1});
    assign pulse_out = en_in & last;

    // Count enabled cycles, restarting on clear
    always @(posedge clk_in)
    begin
        if (rst_in || clr_in)
            cnt <= {W{1'b0}};
        else if (en_in)
            cnt <= last ? {W{1'b0}} : cnt + {{(W-1){1'b0}}, 1'b1};
    end
endmodule // fctc_divider
`default_nettype wire

// File: design/fctc_sat_counter.v
// Saturating up counter for the tachometer period
`default_nettype none
module fctc_sat_counter #(
    parameter W = 8
) (
    input wire clk_in,
    input wire rst_in,
    input wire clr_in,
    input wire inc_in,
    output reg [W-1:0] count_out,
    output wire full_out
);
    // Full scale flags a stalled or absent fan
    assign full_out = &count_out;

    // Hold at full scale rather than wrapping to a small count
    always @(posedge clk_in)
    begin
        if (rst_in || clr_in)
            count_out <= {W{1'b0}};
        else if (inc_in && !full_out)
            count_out <= count_out + {{(W-1){1'b0}}, 1'b1};
    end
endmodule // fctc_sat_counter
`default_nettype wire

// File: design/fctc_top.v
// Fan tachometer period counter with APB registers and alert output
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "fctc_defines.vh"
`default_nettype none
module fctc_top #(
    parameter CNT_W = 8,
    parameter REF_DIV = `FCTC_CLK_HZ / `FCTC_REF_HZ
) (
    input wire clk_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Tachometer pins, synchronous to clk_in
    input wire first_tach_input_in,
    input wire second_tach_input_in,
    // Voltage id bits shown in the low nibble
    input wire [3:0] vid_in,
    // Alert and monitoring state
    output reg irq_out,
    output reg monitor_active_out
);
    // Software registers
    reg [7:0] cfg; // Start, alert enable, alert clear
    reg [1:0] chmode; // One bit per shared pin, 1 = analog
    reg [3:0] div_sel; // Two divisor fields
    reg [CNT_W-1:0] val1; // Latest first fan count
    reg [CNT_W-1:0] val2; // Latest second fan count
    reg [CNT_W-1:0] lim1; // First fan low-speed limit
    reg [CNT_W-1:0] lim2; // Second fan low-speed limit
    reg [1:0] stat; // Sticky fault events
    reg [1:0] mask; // 1 blocks the status bit from the alert
    reg [1:0] fault; // Result of the latest comparison per fan

    // Measurement state
    reg [1:0] state; // Sequencer state
    reg fan_sel; // 0 first fan, 1 second fan
    reg edges; // Rising edges seen since counting opened
    reg [1:0] tach_q; // Registered pins
    reg [1:0] tach_prev; // Previous pin levels

    // Bus decode
    wire acc; // Access phase with answer given this edge
    wire wr; // Write takes effect at this edge
    reg [31:0] next_rdata; // Read mux
    reg next_err; // Unmapped address

    // Derived control
    wire run; // Monitoring running
    wire [1:0] fan_on; // Pin in fan mode
    wire tach_rise; // Rising edge on the selected pin
    wire ref_tick; // Reference oscillator enable
    wire pre_tick; // Counter enable after prescaler
    wire [1:0] div_code; // Selected fan's divisor field
    wire [3:0] div_ratio; // 1, 2, 4 or 8
    wire [CNT_W-1:0] count; // Running count
    wire full; // Count at full scale
    wire cnt_clr; // Counter held clear outside counting
    wire [CNT_W-1:0] cur_lim; // Limit of fan being measured
    wire over; // Count beyond limit
    wire [1:0] ev; // Fault events from this store
    wire [1:0] w1c; // Status bits cleared by software

    assign acc = psel_in & penable_in & pready_out;
    assign wr = acc & pwrite_in;

    // Start bit high and alert-clear low start the fan monitoring cycle
    assign run = cfg[`FCTC_CFG_START] & ~cfg[`FCTC_CFG_ALERT_CLR];

    // A zero mode bit leaves the pin as a tachometer input
    assign fan_on = ~chmode;

    assign tach_rise = tach_q[fan_sel] & ~tach_prev[fan_sel];

    // Each fan has its own divisor field
    assign div_code = fan_sel ? div_sel[3:2] : div_sel[1:0];
    assign div_ratio = 4'h1 << div_code;

    assign cnt_clr = (state != `FCTC_S_CNT);
    assign cur_lim = fan_sel ? lim2 : lim1;

    // Period grows as speed falls, so only an excess is a fault
    assign over = (count > cur_lim);
    assign ev = (state == `FCTC_S_DONE && over) ? (fan_sel ? 2'h2 : 2'h1) : 2'h0;
    assign w1c = (wr && paddr_in == `FCTC_OFS_STAT) ? pwdata_in[1:0] : 2'h0;

    // Free-running reference oscillator derived from the system clock
    fctc_divider #(
        .W(`FCTC_REF_DIV_W)
    ) u_ref (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clr_in(1'b0),
        .en_in(1'b1),
        .ratio_in(REF_DIV[`FCTC_REF_DIV_W-1:0]),
        .pulse_out(ref_tick)
    );

    // Prescaler restarts with each measurement so every count is whole
    fctc_divider #(
        .W(4)
    ) u_pre (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clr_in(cnt_clr),
        .en_in(ref_tick),
        .ratio_in(div_ratio),
        .pulse_out(pre_tick)
    );

    // Reference ticks gated into the period counter while open
    fctc_sat_counter #(
        .W(CNT_W)
    ) u_cnt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clr_in(cnt_clr),
        .inc_in(pre_tick),
        .count_out(count),
        .full_out(full)
    );

    // Register the pins and keep last levels for edge finding
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            tach_q <= 2'h0;
            tach_prev <= 2'h0;
        end
        else
        begin
            tach_q <= {second_tach_input_in, first_tach_input_in};
            tach_prev <= tach_q;
        end
    end

    // Measurement sequencer: one fan at a time, alternating
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= `FCTC_S_IDLE;
            fan_sel <= 1'b0;
            edges <= 1'b0;
        end
        else if (!run)
            state <= `FCTC_S_IDLE;
        else
        begin
            case (state)
                `FCTC_S_IDLE:
                begin
                    // Pick the first pin in fan mode
                    if (fan_on != 2'h0)
                    begin
                        fan_sel <= ~fan_on[0];
                        state <= `FCTC_S_ARM;
                    end
                end
                `FCTC_S_ARM:
                begin
                    // Wait for the opening rising edge
                    if (!fan_on[fan_sel])
                        state <= `FCTC_S_IDLE;
                    else if (tach_rise)
                    begin
                        edges <= 1'b0;
                        state <= `FCTC_S_CNT;
                    end
                end
                `FCTC_S_CNT:
                begin
                    // Close on the second following edge or at full scale
                    if (!fan_on[fan_sel])
                        state <= `FCTC_S_IDLE;
                    else if (full)
                        state <= `FCTC_S_DONE;
                    else if (tach_rise)
                    begin
                        if (edges)
                            state <= `FCTC_S_DONE;
                        else
                            edges <= 1'b1;
                    end
                end
                `FCTC_S_DONE:
                begin
                    // Move to the other fan if it is in fan mode
                    if (fan_on[~fan_sel])
                        fan_sel <= ~fan_sel;
                    state <= `FCTC_S_ARM;
                end
                default:
                    state <= `FCTC_S_IDLE;
            endcase
        end
    end

    // Store results and live comparison on each completed measurement
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            val1 <= {CNT_W{1'b0}};
            val2 <= {CNT_W{1'b0}};
            fault <= 2'h0;
        end
        else if (state == `FCTC_S_DONE)
        begin
            if (fan_sel)
            begin
                val2 <= count;
                fault[1] <= over;
            end
            else
            begin
                val1 <= count;
                fault[0] <= over;
            end
        end
    end

    // Sticky status: a new event wins over a same-cycle clear
    always @(posedge clk_in)
    begin
        if (rst_in)
            stat <= 2'h0;
        else
            stat <= (stat & ~w1c) | ev;
    end

    // Software writable registers
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg <= 8'h00;
            chmode <= 2'h0;
            div_sel <= `FCTC_VIDDIV_RST;
            lim1 <= `FCTC_LIM_RST;
            lim2 <= `FCTC_LIM_RST;
            mask <= 2'h0;
        end
        else if (wr)
        begin
            case (paddr_in)
                `FCTC_OFS_CONFIG: cfg <= pwdata_in[7:0];
                `FCTC_OFS_CHMODE: chmode <= pwdata_in[1:0];
                `FCTC_OFS_VIDDIV: div_sel <= pwdata_in[7:`FCTC_DIV1_LSB];
                `FCTC_OFS_LIM1: lim1 <= pwdata_in[CNT_W-1:0];
                `FCTC_OFS_LIM2: lim2 <= pwdata_in[CNT_W-1:0];
                `FCTC_OFS_MASK: mask <= pwdata_in[1:0];
                default: cfg <= cfg;
            endcase
        end
    end

    // Read mux; value registers readable at any time
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr_in)
            `FCTC_OFS_CONFIG: next_rdata[7:0] = cfg;
            `FCTC_OFS_CHMODE: next_rdata[1:0] = chmode;
            `FCTC_OFS_VIDDIV: next_rdata[7:0] = {div_sel, vid_in};
            `FCTC_OFS_VAL1: next_rdata[CNT_W-1:0] = val1;
            `FCTC_OFS_VAL2: next_rdata[CNT_W-1:0] = val2;
            `FCTC_OFS_LIM1: next_rdata[CNT_W-1:0] = lim1;
            `FCTC_OFS_LIM2: next_rdata[CNT_W-1:0] = lim2;
            `FCTC_OFS_STAT: next_rdata[1:0] = stat;
            `FCTC_OFS_MASK: next_rdata[1:0] = mask;
            `FCTC_OFS_FAULT: next_rdata[1:0] = fault;
            default: next_err = 1'b1;
        endcase
    end

    // APB answer one cycle into the access phase, from flops
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= psel_in & penable_in & ~pready_out & next_err;
            if (psel_in && penable_in && !pready_out && !pwrite_in)
                prdata_out <= next_rdata;
        end
    end

    // Alert pin driven only while enabled and not being cleared
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            irq_out <= 1'b0;
            monitor_active_out <= 1'b0;
        end
        else
        begin
            irq_out <= cfg[`FCTC_CFG_ALERT_EN] & ~cfg[`FCTC_CFG_ALERT_CLR]
                & (|(stat & ~mask));
            monitor_active_out <= run;
        end
    end
endmodule // fctc_top
`default_nettype wire

// File: test/fctc_fan_model.sv
// Behavioural cooling fan giving a tach square wave of a set period
`default_nettype none
module fctc_fan_model (
    input wire logic clk_in,
    input wire logic [15:0] period_in,
    output var logic tach_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] phase = 16'h0; // Clocks into the current period
    // High in the first half; a long period stands in for a failing rotor
    always @(posedge clk_in)
    begin
        phase <= (phase + 16'h1 >= period_in) ? 16'h0 : phase + 16'h1;
        tach_out <= phase < (period_in >> 1);
    end
endmodule // fctc_fan_model
`default_nettype wire

// File: test/fctc_monitor.sv
// Port checker for the fan tachometer period counter
`default_nettype none
module fctc_monitor #(
    parameter CNT_W = 8,
    parameter REF_DIV = 2222
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic first_tach_input_in,
    input wire logic second_tach_input_in,
    input wire logic [3:0] vid_in,
    input wire logic irq_out,
    input wire logic monitor_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // Completed read, and completed write to the configuration word
    wire logic rd_done = psel_in && penable_in && pready_out && !pwrite_in;
    wire logic cfg_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00;
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held over one cycle");
    a_ready_delay: assert property (psel_in && $rose(penable_in) |=> pready_out)
        else $error("access not answered after one cycle");
    a_unmapped_err: assert property (pready_out && paddr_in > 8'h24 |-> pslverr_out)
        else $error("unmapped access without error");
    a_start_run:
        assert property (cfg_wr && pwdata_in[0] && !pwdata_in[3] |-> ##[1:2] monitor_active_out)
        else $error("monitoring did not start");
    a_run_cause:
        assert property ($changed(monitor_active_out) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("monitoring changed without a configuration write");
    a_vid_field:
        assert property (rd_done && paddr_in == 8'h08 && $stable(vid_in)
            |-> prdata_out[3:0] == vid_in && prdata_out[31:8] == 24'h0)
        else $error("voltage id field wrong");
    a_value_width:
        assert property (rd_done && (paddr_in == 8'h0c || paddr_in == 8'h10)
            |-> prdata_out[31:CNT_W] == '0) else $error("count wider than counter");
    a_fault_width:
        assert property (rd_done && paddr_in == 8'h24 |-> prdata_out[31:2] == 30'h0)
        else $error("fault word has stray bits");
    c_alert: cover property ($rose(irq_out));
    c_run: cover property ($rose(monitor_active_out));
    c_refused: cover property (pslverr_out);
endmodule // fctc_monitor
bind fctc_top fctc_monitor #(.CNT_W(CNT_W), .REF_DIV(REF_DIV)) i_mon (.clk_in(clk_in),
    .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .vid_in(vid_in),
    .first_tach_input_in(first_tach_input_in), .second_tach_input_in(second_tach_input_in),
    .irq_out(irq_out), .monitor_active_out(monitor_active_out));
`default_nettype wire

// File: test/fctc_top_bench.sv
// Self-checking bench for the fan tachometer period counter
`default_nettype none
module fctc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD = 4; // Short reference divider keeps runs brief
    localparam int P1 = 64;
    localparam int P2 = 96;
    logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h2569;
    logic pready, pslverr, irq, active, tach1, tach2;
    logic [15:0] per1 = 16'(P1), per2 = 16'(P2);
    logic [3:0] vid = 4'h0;
    logic [40:0] notes[$]; // Tolerance, error flag and data of each pending read
    logic [40:0] n;
    int fail_count = 0, num_checks = 0;
    always #10 clk_in = ~clk_in;
    fctc_top #(.REF_DIV(RD)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .first_tach_input_in(tach1), .second_tach_input_in(tach2), .vid_in(vid),
        .irq_out(irq), .monitor_active_out(active));
    fctc_fan_model i_first_tach_input (.clk_in(clk_in), .period_in(per1), .tach_out(tach1));
    fctc_fan_model i_second_tach_input (.clk_in(clk_in), .period_in(per2), .tach_out(tach2));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Counts may be one off because ref ticks and tach edges are unrelated
    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] tol);
        logic ok;
        ok = (got === exp) || ((got + tol >= exp) === 1'b1 && (got <= exp + tol) === 1'b1);
        num_checks++;
        if (!ok)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One full bus transfer; an idle edge follows so strobes never toggle twice
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1)
            @(posedge clk_in);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [7:0] tol);
        notes.push_back({tol, a > 8'h24, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Oldest note is matched against each read as its answer arrives
    always @(posedge clk_in)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
        begin
            n = notes.pop_front();
            compare(prdata, n[31:0], n[40:33]);
            compare({31'h0, pslverr}, {31'h0, n[32]}, 8'h0);
        end
    end
    initial
    begin
        repeat (30000) @(posedge clk_in);
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        seed = xs(seed);
        vid <= seed[3:0];
        @(posedge clk_in);
        rd(8'h00, 32'h0, 8'h0);
        rd(8'h04, 32'h0, 8'h0);
        rd(8'h08, {24'h0, 4'h5, vid}, 8'h0);
        rd(8'h14, 32'hff, 8'h0);
        rd(8'h40, 32'h0, 8'h0);
        apb(1'b1, 8'h00, 32'h3);
        // Active flag is launched on the edge the write task returns on
        @(posedge clk_in);
        compare({31'h0, active}, 32'h1, 8'h0);
        // Every divisor code; low nibble written with noise as it is read-only
        for (int d = 0; d < 4; d++)
        begin
            seed = xs(seed);
            apb(1'b1, 8'h08, {seed[31:8], 2'(d), 2'(d), seed[3:0]});
            repeat (1200) @(posedge clk_in);
            rd(8'h08, {24'h0, 2'(d), 2'(d), vid}, 8'h0);
            rd(8'h0c, 32'(2 * P1 / (RD << d)), 8'h1);
            rd(8'h10, 32'(2 * P2 / (RD << d)), 8'h1);
        end
        apb(1'b1, 8'h08, 32'h50);
        apb(1'b1, 8'h14, 32'hc);
        apb(1'b1, 8'h18, 32'h1e);
        repeat (1200) @(posedge clk_in);
        rd(8'h1c, 32'h1, 8'h0);
        rd(8'h24, 32'h1, 8'h0);
        compare({31'h0, irq}, 32'h1, 8'h0);
        apb(1'b1, 8'h20, 32'h1);
        repeat (2) @(posedge clk_in);
        compare({31'h0, irq}, 32'h0, 8'h0);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b1, 8'h14, 32'hff);
        repeat (1200) @(posedge clk_in);
        rd(8'h24, 32'h0, 8'h0);
        rd(8'h1c, 32'h1, 8'h0);
        apb(1'b1, 8'h1c, 32'h1);
        rd(8'h1c, 32'h0, 8'h0);
        repeat (2) @(posedge clk_in);
        compare({31'h0, irq}, 32'h0, 8'h0);
        per1 <= 16'd2000;
        repeat (13000) @(posedge clk_in);
        rd(8'h0c, 32'hff, 8'h0);
        rd(8'h10, 32'h18, 8'h1);
        // First pin to analog: only the second fan is measured, first value frozen
        per2 <= 16'd112;
        apb(1'b1, 8'h04, 32'h1);
        repeat (1200) @(posedge clk_in);
        rd(8'h04, 32'h1, 8'h0);
        rd(8'h0c, 32'hff, 8'h0);
        rd(8'h10, 32'h1c, 8'h1);
        apb(1'b1, 8'h00, 32'hb);
        repeat (2) @(posedge clk_in);
        compare({31'h0, active}, 32'h0, 8'h0);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(8'h0c, 32'h0, 8'h0);
        complete_run();
    end
endmodule // fctc_top_bench
`default_nettype wire
